// ===== shared/trr_pkg.sv
package trr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TRR_OFS_LOCAL_TEMP   = 8'h00;
    localparam logic [7:0] TRR_OFS_REMOTE_UPPER = 8'h01;
    localparam logic [7:0] TRR_OFS_LOCAL_LIMIT  = 8'h05;
    localparam logic [7:0] TRR_OFS_REMOTE_LOWER = 8'h10;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] TRR_RST_LOCAL_LIMIT  = 8'h46;   // 70 degC
    localparam logic [7:0] TRR_RST_RESULT       = 8'h00;
    localparam logic [7:0] TRR_RDATA_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------
    // remote sample layout: signed, 1/32 degC per lsb
    // ------------------------------------------------------------
    localparam int unsigned TRR_SAMPLE_W       = 16;
    localparam int unsigned TRR_FRAC_W         = 5;
    localparam int unsigned TRR_UPPER_LSB      = 5;     // 1 degC bit
    localparam int unsigned TRR_UPPER_MSB      = 12;    // sign of the upper byte
    localparam int unsigned TRR_FRAC3_MSB      = 4;     // 0.5 degC bit
    localparam int unsigned TRR_FRAC3_LSB      = 2;     // 0.125 degC bit
    localparam int unsigned TRR_LOW2_MSB       = 1;     // 0.0625 degC bit
    localparam logic signed [15:0] TRR_SAMPLE_MAX = 16'sh0FFC;   // 127.875 degC
    localparam logic signed [15:0] TRR_SAMPLE_MIN = 16'shF000;   // -128.0 degC

    // ------------------------------------------------------------
    // upper and lower byte field values
    // ------------------------------------------------------------
    localparam logic [7:0] TRR_UPPER_SAT_HI    = 8'h7F;
    localparam logic [7:0] TRR_UPPER_SAT_LO    = 8'h80;
    localparam logic [2:0] TRR_FRAC3_SAT_HI    = 3'h7;
    localparam logic [2:0] TRR_FRAC3_ZERO      = 3'h0;
    localparam logic [1:0] TRR_LOW2_ONES       = 2'h3;
    localparam logic [1:0] TRR_LOW2_ZERO       = 2'h0;
    localparam logic [2:0] TRR_LOWER_UNUSED    = 3'h0;

endpackage

// ===== shared/trr_fmt_if.sv
interface trr_fmt_if;
    import trr_pkg::*;

    logic                    sample_valid;
    logic [TRR_SAMPLE_W-1:0] sample;
    logic                    filter_on;
    logic                    extended_on;
    logic [7:0]              upper;
    logic [7:0]              lower;

    modport ctrl (
        output sample_valid,
        output sample,
        output filter_on,
        output extended_on,
        input  upper,
        input  lower
    );

    modport fmt (
        input  sample_valid,
        input  sample,
        input  filter_on,
        input  extended_on,
        output upper,
        output lower
    );
endinterface

// ===== rtl/trr_remote_format.sv
module trr_remote_format
    import trr_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    trr_fmt_if.fmt    fmt
);

    // ------------------------------------------------------------
    // range checks on the incoming sample
    // ------------------------------------------------------------
    // the signed format cannot show more than 127.875 or less than -128
    function automatic logic over_range(input logic [TRR_SAMPLE_W-1:0] s);
        over_range = $signed(s) > TRR_SAMPLE_MAX;
    endfunction

    function automatic logic under_range(input logic [TRR_SAMPLE_W-1:0] s);
        under_range = $signed(s) < TRR_SAMPLE_MIN;
    endfunction

    logic       over_w;
    logic       under_w;
    logic [7:0] upper_nxt;
    logic [2:0] frac3_nxt;
    logic [1:0] low2_nxt;

    assign over_w  = over_range(fmt.sample);
    assign under_w = under_range(fmt.sample);

    // ------------------------------------------------------------
    // upper byte and top fraction bits
    // ------------------------------------------------------------
    always_comb begin
        if (over_w) begin
            upper_nxt = TRR_UPPER_SAT_HI;
            frac3_nxt = TRR_FRAC3_SAT_HI;
        end else if (under_w) begin
            upper_nxt = TRR_UPPER_SAT_LO;
            frac3_nxt = TRR_FRAC3_ZERO;
        end else begin
            upper_nxt = fmt.sample[TRR_UPPER_MSB:TRR_UPPER_LSB];   // R03
            frac3_nxt = fmt.sample[TRR_FRAC3_MSB:TRR_FRAC3_LSB];   // R05
        end
    end

    // ------------------------------------------------------------
    // two lowest fraction bits, by filter and resolution mode
    // ------------------------------------------------------------
    always_comb begin
        if (fmt.filter_on && fmt.extended_on) begin
            // 1/16 and 1/32 degC from the filtered sample
            if (over_w) begin
                low2_nxt = TRR_LOW2_ONES;
            end else if (under_w) begin
                low2_nxt = TRR_LOW2_ZERO;
            end else begin
                low2_nxt = fmt.sample[TRR_LOW2_MSB:0];   // R08
            end
        end else if (!fmt.filter_on && fmt.extended_on) begin
            low2_nxt = over_w ? TRR_LOW2_ONES : TRR_LOW2_ZERO;   // R07
        end else begin
            low2_nxt = TRR_LOW2_ZERO;   // R06
        end
    end

    // ------------------------------------------------------------
    // result registers, loaded once per sample
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fmt.upper <= TRR_RST_RESULT;
            fmt.lower <= TRR_RST_RESULT;
        end else if (fmt.sample_valid) begin
            fmt.upper <= upper_nxt;
            fmt.lower <= {frac3_nxt, low2_nxt, TRR_LOWER_UNUSED};   // R09
        end
    end

endmodule

// ===== rtl/trr_temperature_results.sv
// How it works
// R01 - the local die reading is held and read back as an 8-bit signed whole-degree value.
// R02 - the local high limit is an 8-bit signed read/write register that starts at 0x46 (70 degC).
// R03 - the upper remote byte is two's complement, sign in bit 7 and 1 degC in bit 0.
// R04 - the host reads the upper remote byte first; that read freezes the matching lower byte.
// R05 - bits 7:5 of the lower remote byte carry 0.5, 0.25 and 0.125 degC.
// R06 - with filter off and extended resolution off, the two lowest fraction bits read 00.
// R07 - with extended resolution on and filter off, those bits read 11 above 127.875 degC, else 00.
// R08 - with filter and extended resolution both on, those bits carry 0.0625 and 0.03125 degC.
// R09 - bits 2:0 of the lower remote byte always read zero.
// R10 - a local reading above the programmed high limit raises the over-limit flag.
module trr_temperature_results
    import trr_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    resetn_i,
    // measurement side, same clock
    input  wire logic                    local_valid_i,
    input  wire logic [7:0]              local_sample_i,
    input  wire logic                    remote_valid_i,
    input  wire logic [TRR_SAMPLE_W-1:0] remote_sample_i,
    input  wire logic                    filter_enable_i,
    input  wire logic                    extended_range_select_i,
    // register port
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_rd_i,
    output logic      [7:0]              reg_rdata_o,
    output logic                         reg_rvalid_o,
    // status
    output logic                         local_over_limit_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] local_temp_value_r;
    logic [7:0] local_high_limit_value_r;
    logic [7:0] remote_lower_hold_r;
    logic       over_limit_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic [7:0] rdata_nxt;

    trr_fmt_if fmt_bus ();

    // ------------------------------------------------------------
    // remote formatting
    // ------------------------------------------------------------
    assign fmt_bus.sample_valid = remote_valid_i;
    assign fmt_bus.sample       = remote_sample_i;
    assign fmt_bus.filter_on    = filter_enable_i;
    assign fmt_bus.extended_on  = extended_range_select_i;

    trr_remote_format u_fmt (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .fmt      (fmt_bus.fmt)
    );

    // ------------------------------------------------------------
    // local reading capture
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            local_temp_value_r <= TRR_RST_RESULT;
        end else if (local_valid_i) begin
            local_temp_value_r <= local_sample_i;   // R01
        end
    end

    // ------------------------------------------------------------
    // local high limit register
    // ------------------------------------------------------------
    // writes to read-only or unmapped offsets are dropped silently
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            local_high_limit_value_r <= TRR_RST_LOCAL_LIMIT;   // R02
        end else if (reg_wr_i && reg_addr_i == TRR_OFS_LOCAL_LIMIT) begin
            local_high_limit_value_r <= reg_wdata_i;   // R02
        end
    end

    // ------------------------------------------------------------
    // lower byte snapshot
    // ------------------------------------------------------------
    // a new sample between the two reads would otherwise tear the value
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remote_lower_hold_r <= TRR_RST_RESULT;
        end else if (reg_rd_i && reg_addr_i == TRR_OFS_REMOTE_UPPER) begin
            remote_lower_hold_r <= fmt_bus.lower;   // R04
        end
    end

    // ------------------------------------------------------------
    // over-limit compare
    // ------------------------------------------------------------
    // signed compare, one cycle behind a new reading or limit write
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            over_limit_r <= 1'b0;
        end else begin
            over_limit_r <= $signed(local_temp_value_r) > $signed(local_high_limit_value_r);   // R10
        end
    end

    assign local_over_limit_o = over_limit_r;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr_i)
            TRR_OFS_LOCAL_TEMP:   rdata_nxt = local_temp_value_r;   // R01
            TRR_OFS_REMOTE_UPPER: rdata_nxt = fmt_bus.upper;        // R03
            TRR_OFS_LOCAL_LIMIT:  rdata_nxt = local_high_limit_value_r;
            TRR_OFS_REMOTE_LOWER: rdata_nxt = remote_lower_hold_r;  // R04
            default:              rdata_nxt = TRR_RDATA_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r  <= TRR_RDATA_UNMAPPED;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

endmodule

// ===== tb/trr_temperature_results_assertions.sv
module trr_temperature_results_assertions
    import trr_pkg::*;
(
    input wire logic                    clock_i,
    input wire logic                    resetn_i,
    input wire logic                    local_valid_i,
    input wire logic [7:0]              local_sample_i,
    input wire logic                    remote_valid_i,
    input wire logic [TRR_SAMPLE_W-1:0] remote_sample_i,
    input wire logic [7:0]              reg_addr_i,
    input wire logic                    reg_wr_i,
    input wire logic [7:0]              reg_wdata_i,
    input wire logic                    reg_rd_i,
    input wire logic [7:0]              reg_rdata_o,
    input wire logic                    reg_rvalid_o,
    input wire logic                    local_over_limit_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] loc_r;
    logic [7:0] lim_r;
    // shadow copies, so reads can be tied to their cause
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            loc_r <= 8'h00;
        end else if (local_valid_i) begin
            loc_r <= local_sample_i;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lim_r <= TRR_RST_LOCAL_LIMIT;
        end else if (reg_wr_i && reg_addr_i == TRR_OFS_LOCAL_LIMIT) begin
            lim_r <= reg_wdata_i;
        end
    end
    wire over_w = $signed(loc_r) > $signed(lim_r);
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read got no answer");
    a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without read");
    a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved");
    a_local_read: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == $past(loc_r))
        else $error("local reading wrong");
    a_limit_read: assert property (reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o == $past(lim_r))
        else $error("limit readback wrong");
    a_over_flag: assert property (local_over_limit_o == $past(over_w))
        else $error("over-limit flag wrong");
    a_lower_unused: assert property (reg_rvalid_o && $past(reg_addr_i) == 8'h10 |-> reg_rdata_o[2:0] == 3'h0)
        else $error("unused low bits set");
    a_upper_sat: assert property (remote_valid_i && $signed(remote_sample_i) > TRR_SAMPLE_MAX ##1
        reg_rd_i && reg_addr_i == 8'h01 |=> reg_rdata_o == 8'h7F)
        else $error("upper byte not saturated");
    c_limit_write: cover property (reg_wr_i && reg_addr_i == 8'h05);
    c_over: cover property (local_over_limit_o);
    c_floor: cover property (remote_valid_i && $signed(remote_sample_i) < TRR_SAMPLE_MIN);
endmodule

bind trr_temperature_results trr_temperature_results_assertions u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .local_valid_i(local_valid_i), .local_sample_i(local_sample_i), .remote_valid_i(remote_valid_i),
    .remote_sample_i(remote_sample_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .local_over_limit_o(local_over_limit_o));

// ===== tb/trr_host_model.sv
module trr_host_model (
    input  wire logic       clock_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] exp_q[$];
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    // one strobe per falling edge, held until the next call
    task automatic req(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(negedge clock_i);
        reg_rd_o    = r;
        reg_wr_o    = w;
        reg_addr_o  = a;
        reg_wdata_o = d;
        if (r) begin
            exp_q.push_back(e);
        end
    endtask
    // released bus shows the inverse, so stale values never pass
    task automatic idle();
        req(1'b0, 1'b0, ~reg_addr_o, ~reg_wdata_o, 8'h00);
    endtask
    // upper first: both halves then come from one sample
    task automatic rd_pair(input logic [7:0] eu, input logic [7:0] el);
        req(1'b1, 1'b0, 8'h01, ~reg_wdata_o, eu);
        req(1'b1, 1'b0, 8'h10, ~reg_wdata_o, el);
    endtask
endmodule

// ===== tb/test_temperature_result_registers.sv
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
module test_temperature_result_registers
    import trr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, resetn_i, local_valid_i, remote_valid_i, filter_enable_i, extended_range_select_i;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, local_over_limit_o;
    logic [7:0] local_sample_i, reg_addr_i, reg_wdata_i, reg_rdata_o, lim, smp, exp_b;
    logic [15:0] remote_sample_i, ex, s16;
    logic [15:0] rst_tab[5] = '{16'h0000, 16'h0100, 16'h0546, 16'h1000, 16'h2200};
    logic [15:0] rtab[6] = '{16'h0000, 16'h0FFC, 16'h0FFD, 16'hF000, 16'hEFFF, 16'h0FFF};
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    trr_temperature_results u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .local_valid_i(local_valid_i),
        .local_sample_i(local_sample_i), .remote_valid_i(remote_valid_i), .remote_sample_i(remote_sample_i),
        .filter_enable_i(filter_enable_i), .extended_range_select_i(extended_range_select_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .local_over_limit_o(local_over_limit_o));
    trr_host_model u_host (.clock_i(clock_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic print_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // remote sample to {upper, lower} as the host should see it
    function automatic logic [15:0] rexp(input logic [15:0] s, input logic f, input logic e);
        if ($signed(s) > TRR_SAMPLE_MAX) begin
            return {8'h7F, 3'h7, e ? 2'h3 : 2'h0, 3'h0};
        end
        if ($signed(s) < TRR_SAMPLE_MIN) begin
            return 16'h8000;
        end
        return {s[12:5], s[4:2], (f & e) ? s[1:0] : 2'h0, 3'h0};
    endfunction
    // answers settle before the falling edge; oldest note first
    // an answer with no note behind it is forced to mismatch
    always @(negedge clock_i) begin
        if (reg_rvalid_o === 1'b1) begin
            exp_b = (u_host.exp_q.size() > 0) ? u_host.exp_q.pop_front() : ~reg_rdata_o;
            `CHK("rdata", exp_b, reg_rdata_o)
        end
        cyc++;
        if (cyc == 3000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        resetn_i = 1'b0;
        local_valid_i = 1'b0;
        local_sample_i = 8'h00;
        remote_valid_i = 1'b0;
        remote_sample_i = 16'h0000;
        filter_enable_i = 1'b0;
        extended_range_select_i = 1'b0;
        void'($urandom(32'h6a92_a773));
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        foreach (rst_tab[i]) u_host.req(1'b1, 1'b0, rst_tab[i][15:8], 8'h00, rst_tab[i][7:0]);
        u_host.idle();
        $display("test reset values done");
        for (int i = 0; i < 24; i++) begin
            lim = 8'($urandom);
            smp = (i % 4 == 0) ? lim : 8'($urandom);
            u_host.req(1'b0, 1'b1, 8'h05, lim, 8'h00);
            u_host.req(1'b0, 1'b1, 8'h00, ~smp, 8'h00);
            local_valid_i = 1'b1;
            local_sample_i = smp;
            u_host.req(1'b1, 1'b0, 8'h00, 8'h00, smp);
            local_valid_i = 1'b0;
            u_host.req(1'b1, 1'b1, 8'h05, ~lim, lim);
            u_host.idle();
            `CHK("over", $signed(smp) > $signed(lim), local_over_limit_o)
        end
        $display("test local and limit done");
        foreach (rtab[k]) for (int m = 0; m < 4; m++) begin
            s16 = (k == 0) ? 16'($signed($urandom_range(4095, 0) - 2048) <<< 1) : rtab[k];
            filter_enable_i = m[0];
            extended_range_select_i = m[1];
            remote_valid_i = 1'b1;
            remote_sample_i = s16;
            ex = rexp(s16, m[0], m[1]);
            u_host.rd_pair(ex[15:8], ex[7:0]);
            remote_sample_i = ~s16;
            u_host.req(1'b1, 1'b0, 8'h10, 8'h00, ex[7:0]);
        end
        // valid stays high across the table so it is never set twice in one step
        remote_valid_i = 1'b0;
        u_host.idle();
        repeat (3) @(negedge clock_i);
        $display("test remote formats done");
        `CHK("pending reads", 0, u_host.exp_q.size())
        print_verdict();
    end
endmodule
